//--- rtl/sdu_defs.svh
// Register offsets, field positions, reset values and cycle counts of the divide unit
`ifndef SDU_DEFS_SVH
`define SDU_DEFS_SVH

// ----------------------------------------
// Register map (byte offsets)
// ----------------------------------------
`define SDU_ADDR_W       8
`define SDU_OFF_DIVISOR  8'h00
`define SDU_OFF_SHORT    8'h04
`define SDU_OFF_CTRL     8'h08
`define SDU_OFF_VECTOR   8'h0c
`define SDU_OFF_HIGH     8'h10
`define SDU_OFF_LOW      8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SDU_CTRL_IE_BIT  1
`define SDU_CTRL_OVF_BIT 0
`define SDU_VEC_W        7
`define SDU_VEC_RST      7'h00
`define SDU_Q_MAX        32'h7fffffff
`define SDU_Q_MIN        32'h80000000

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define SDU_CNT_W        6
`define SDU_NORM_CYC     6'd39
`define SDU_OVF_CYC      6'd6
`define SDU_FLAG_CYC     6'd3
`define SDU_STEPS        6'd32

`endif

//--- rtl/sdu_divide_unit.sv
// Memory-mapped signed divide unit, 64/32 and 32/32
//
// What this block does
// - High register holds dividend top, then remainder
// - Short start write sign-extends into high register
// - Dividend registers have no reset value
// - Low register write starts 64/32 division
// - Short start write also copies into low
// - Long result: quotient low, remainder high
// - Short start runs 32/32, quotient there, remainder high
// - Operands and results are two's-complement signed
// - Normal division finishes in 39 cycles
// - Overflow ends after 6 cycles, 3 flag, 3 steps
// - Overflow on zero divisor, unrepresentable quotient, or two negatives giving top quotient with a remainder
// - Overflow sets flag; request only when enabled
// - Enabled overflow leaves intermediate in both registers
// - Disabled overflow saturates quotient, keeps high intermediate
// - Overflow flag sticky, cleared only by software
// - Read right after write waits one cycle
// - Accesses during a division wait until done
// - Divisor register kept unchanged by division
// - Control: enable bit 1, flag bit 0
// - Vector register holds 7-bit vector number
`timescale 1ns/1ps
`include "sdu_defs.svh"

module sdu_divide_unit (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// Register port
	input  wire logic [`SDU_ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]            bus_wdata,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	output logic      [31:0]            bus_rdata,
	output logic                        bus_rd_valid,
	output logic                        bus_stall,
	// Status and interrupt
	output logic                        busy,
	output logic                        overflow_irq_request,
	output logic      [`SDU_VEC_W-1:0]  irq_vector
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [63:0] sdu_abs64(input logic [63:0] x);
		sdu_abs64 = x[63] ? (~x + 64'h1) : x;
	endfunction

	function automatic logic [31:0] sdu_neg32(input logic [31:0] x);
		sdu_neg32 = ~x + 32'h1;
	endfunction

	// One restoring step on the {remainder, quotient} pair
	function automatic logic [63:0] sdu_step(input logic [63:0] w, input logic [31:0] d);
		logic [64:0] s;
		logic [32:0] t;
		s = {w, 1'b0};
		t = s[64:32] - {1'b0, d};
		if (s[64:32] >= {1'b0, d}) begin
			s[64:32] = t;
			s[0] = 1'b1;
		end
		sdu_step = s[63:0];
	endfunction

	function automatic logic [31:0] sdu_rmux(
		input logic [`SDU_ADDR_W-1:0] a,
		input logic [31:0]            dv,
		input logic [31:0]            sh,
		input logic [31:0]            hi,
		input logic [31:0]            lo,
		input logic [31:0]            ct,
		input logic [31:0]            vc
	);
		if (a == `SDU_OFF_DIVISOR) begin
			sdu_rmux = dv;
		end else if (a == `SDU_OFF_SHORT) begin
			sdu_rmux = sh;
		end else if (a == `SDU_OFF_CTRL) begin
			sdu_rmux = ct;
		end else if (a == `SDU_OFF_VECTOR) begin
			sdu_rmux = vc;
		end else if (a == `SDU_OFF_HIGH) begin
			sdu_rmux = hi;
		end else if (a == `SDU_OFF_LOW) begin
			sdu_rmux = lo;
		end else begin
			sdu_rmux = 32'h0;
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	sdu_pkg::sdu_state_e        st;
	logic [`SDU_CNT_W-1:0]      cnt;
	logic                       ovf_q;
	logic                       short_q;
	logic                       neg_q;
	logic                       nsign_q;
	logic [31:0]                divisor_reg;
	logic [31:0]                short_dividend_start_reg;
	logic [31:0]                dividend_high_remainder;
	logic [31:0]                dividend_low_quotient;
	logic [63:0]                work;
	logic [63:0]                n_orig;
	logic                       overflow_irq_enable;
	logic                       overflow_flag;
	logic [`SDU_VEC_W-1:0]      vec;
	logic                       pend_valid;
	sdu_pkg::sdu_req_s          pend;
	logic                       last_wr;

	// ----------------------------------------
	// Access arbitration
	// ----------------------------------------
	sdu_pkg::sdu_req_s in_req;
	sdu_pkg::sdu_req_s ex;
	wire               in_any;
	wire               blocked;
	wire               use_pend;
	wire               in_go;
	wire               load_pend;
	wire               next_pend_valid;

	assign in_req = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};
	assign busy = (st == sdu_pkg::SDU_RUN);
	assign in_any = bus_wr | bus_rd;
	// Held while running, while an access is pending, or a read straight after a write
	assign blocked = busy | pend_valid | (bus_rd & last_wr);
	assign use_pend = pend_valid & ~busy & ~(pend.rd & last_wr);
	assign in_go = in_any & ~blocked;
	assign load_pend = in_any & blocked & (~pend_valid | use_pend);
	assign next_pend_valid = load_pend | (pend_valid & ~use_pend);
	// High: a strobe in this cycle would be dropped
	assign bus_stall = pend_valid & ~use_pend;
	assign ex = use_pend ? pend : (in_go ? in_req : '0);

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire wr_div   = ex.wr & (ex.addr == `SDU_OFF_DIVISOR);
	wire wr_short = ex.wr & (ex.addr == `SDU_OFF_SHORT);
	wire wr_ctrl  = ex.wr & (ex.addr == `SDU_OFF_CTRL);
	wire wr_vec   = ex.wr & (ex.addr == `SDU_OFF_VECTOR);
	wire wr_high  = ex.wr & (ex.addr == `SDU_OFF_HIGH);
	wire wr_low   = ex.wr & (ex.addr == `SDU_OFF_LOW);
	wire start    = wr_short | wr_low;

	wire [31:0] ctrl_rd = {30'h0, overflow_irq_enable, overflow_flag};
	wire [31:0] vec_rd  = {25'h0, vec};
	wire [31:0] rd_val  = sdu_rmux(ex.addr, divisor_reg, short_dividend_start_reg,
		dividend_high_remainder, dividend_low_quotient, ctrl_rd, vec_rd);

	// ----------------------------------------
	// Operand set-up and overflow check
	// ----------------------------------------
	wire [31:0] sext_hi = {32{ex.wdata[31]}};
	wire [63:0] n_start = wr_short ? {sext_hi, ex.wdata} : {dividend_high_remainder, ex.wdata};
	wire [63:0] n_mag   = sdu_abs64(n_start);
	wire [31:0] d_mag   = divisor_reg[31] ? sdu_neg32(divisor_reg) : divisor_reg;
	wire        neg_st  = n_start[63] ^ divisor_reg[31];
	wire [63:0] lim_pos = {1'b0, d_mag, 31'h0};
	wire [63:0] lim_neg = lim_pos + {32'h0, d_mag};
	wire [63:0] lim_max = lim_pos - {32'h0, d_mag};
	wire        both_neg = n_start[63] & divisor_reg[31];
	// Quotient magnitude must stay within the signed 32-bit range;
	// two negatives at the top quotient with a remainder left also overflow
	wire        ovf_st  = (divisor_reg == 32'h0) | (neg_st ? (n_mag >= lim_neg) : (n_mag >= lim_pos))
		| (both_neg & (n_mag > lim_max));

	// ----------------------------------------
	// Sequencer timing
	// ----------------------------------------
	wire [`SDU_CNT_W-1:0] last_cnt   = (ovf_q ? `SDU_OVF_CYC : `SDU_NORM_CYC) - 6'd1;
	wire [`SDU_CNT_W-1:0] first_step = ovf_q ? `SDU_FLAG_CYC : (`SDU_NORM_CYC - `SDU_STEPS);
	wire                  fin        = busy & (cnt == last_cnt);
	wire                  step_en    = busy & (cnt >= first_step);
	wire                  set_flag   = busy & ovf_q & (cnt == `SDU_FLAG_CYC - 6'd1);
	wire [63:0]           step_val   = sdu_step(work, d_mag);
	wire [31:0]           q_sgn      = neg_q ? sdu_neg32(step_val[31:0]) : step_val[31:0];
	wire [31:0]           r_sgn      = nsign_q ? sdu_neg32(step_val[63:32]) : step_val[63:32];
	wire [31:0]           q_sat      = neg_q ? `SDU_Q_MIN : `SDU_Q_MAX;
	wire [31:0]           q_ovf      = overflow_irq_enable ? step_val[31:0] : q_sat;
	wire [31:0]           res_lo     = ovf_q ? q_ovf : q_sgn;
	wire [31:0]           res_hi     = ovf_q ? step_val[63:32] : r_sgn;

	wire next_flag = set_flag | (wr_ctrl ? ex.wdata[`SDU_CTRL_OVF_BIT] : overflow_flag);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= sdu_pkg::SDU_IDLE;
			cnt <= '0;
			ovf_q <= 1'b0;
			short_q <= 1'b0;
			neg_q <= 1'b0;
			nsign_q <= 1'b0;
		end else if (start) begin
			st <= sdu_pkg::SDU_RUN;
			cnt <= 6'd1;
			ovf_q <= ovf_st;
			short_q <= wr_short;
			neg_q <= neg_st;
			nsign_q <= n_start[63];
		end else if (fin) begin
			st <= sdu_pkg::SDU_IDLE;
			cnt <= '0;
		end else if (busy) begin
			cnt <= cnt + 6'd1;
		end
	end

	// ----------------------------------------
	// Control, vector and bus state
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow_irq_enable <= 1'b0;
			overflow_flag <= 1'b0;
			vec <= `SDU_VEC_RST;
			pend_valid <= 1'b0;
			pend <= '0;
			last_wr <= 1'b0;
			bus_rdata <= 32'h0;
			bus_rd_valid <= 1'b0;
		end else begin
			overflow_flag <= next_flag;
			if (wr_ctrl) begin
				overflow_irq_enable <= ex.wdata[`SDU_CTRL_IE_BIT];
			end
			if (wr_vec) begin
				vec <= ex.wdata[`SDU_VEC_W-1:0];
			end
			pend_valid <= next_pend_valid;
			if (load_pend) begin
				pend <= in_req;
			end
			last_wr <= ex.wr;
			bus_rd_valid <= ex.rd;
			if (ex.rd) begin
				bus_rdata <= rd_val;
			end
		end
	end

	// ----------------------------------------
	// Data registers, left without reset
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (wr_div) begin
			divisor_reg <= ex.wdata;
		end
		if (wr_short) begin
			short_dividend_start_reg <= ex.wdata;
		end else if (fin & short_q) begin
			short_dividend_start_reg <= res_lo;
		end
		if (wr_short) begin
			dividend_high_remainder <= sext_hi;
		end else if (wr_high) begin
			dividend_high_remainder <= ex.wdata;
		end else if (fin) begin
			dividend_high_remainder <= res_hi;
		end
		if (start) begin
			dividend_low_quotient <= ex.wdata;
		end else if (fin) begin
			dividend_low_quotient <= res_lo;
		end
		if (start) begin
			work <= n_mag;
			n_orig <= n_start;
		end else if (step_en) begin
			work <= step_val;
		end
	end

	assign overflow_irq_request = overflow_flag & overflow_irq_enable;
	assign irq_vector = vec;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_norm_len;
		start && !ovf_st |-> ##38 fin;
	endproperty
	a_norm_len: assert property (p_norm_len) else $error("normal division not done in 39 cycles");

	property p_ovf_len;
		start && ovf_st |=> busy [*5] ##0 fin ##1 !busy;
	endproperty
	a_ovf_len: assert property (p_ovf_len) else $error("overflow run not 6 cycles");

	property p_ovf_flag;
		start && ovf_st |-> ##3 overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_zero_div;
		start && (divisor_reg == 32'h0) |=> ovf_q;
	endproperty
	a_zero_div: assert property (p_zero_div) else $error("zero divisor not flagged");

	property p_neg_max;
		start && both_neg && (n_mag > lim_max) |=> ovf_q;
	endproperty
	a_neg_max: assert property (p_neg_max) else $error("negative pair top quotient not flagged");

	property p_sat;
		fin && ovf_q && !overflow_irq_enable |=>
			(dividend_low_quotient == `SDU_Q_MAX) || (dividend_low_quotient == `SDU_Q_MIN);
	endproperty
	a_sat: assert property (p_sat) else $error("masked overflow not saturated");

	property p_result;
		fin && !ovf_q && !short_q |=>
			$signed(dividend_low_quotient) * $signed(divisor_reg) + $signed(dividend_high_remainder)
			== $signed(n_orig);
	endproperty
	a_result: assert property (p_result) else $error("quotient and remainder wrong");

	property p_short_res;
		fin && !ovf_q && short_q |=> short_dividend_start_reg == dividend_low_quotient;
	endproperty
	a_short_res: assert property (p_short_res) else $error("short quotient not stored");

	property p_sext;
		wr_short |=> (dividend_high_remainder == {32{$past(ex.wdata[31])}})
			&& (dividend_low_quotient == $past(ex.wdata));
	endproperty
	a_sext: assert property (p_sext) else $error("short start copy or extension wrong");

	property p_divisor_keep;
		busy |=> $stable(divisor_reg);
	endproperty
	a_divisor_keep: assert property (p_divisor_keep) else $error("divisor changed by division");

	property p_hold;
		busy && in_any |=> pend_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("access not held while busy");

	property p_rd_wait;
		bus_rd && last_wr && !busy && !pend_valid |=> !bus_rd_valid ##1 bus_rd_valid;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read after write not delayed");

	property p_sticky;
		overflow_flag && !wr_ctrl |=> overflow_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("overflow flag lost");

	property p_irq_drop;
		overflow_irq_request && wr_ctrl && !ex.wdata[`SDU_CTRL_IE_BIT] && !set_flag |=> !overflow_irq_request;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("request stays after disable");

	c_long: cover property (wr_low && !ovf_st ##38 fin);
	c_short: cover property (wr_short && !ovf_st ##38 fin);
	c_ovf_irq: cover property (start && ovf_st && overflow_irq_enable ##3 overflow_irq_request);
	c_held: cover property (busy && bus_rd ##[1:40] bus_rd_valid);
	c_neg_max: cover property (start && both_neg && ovf_st ##5 fin);

endmodule

//--- rtl/sdu_pkg.sv
// Types shared by the divide unit
package sdu_pkg;
`include "sdu_defs.svh"

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic {
		SDU_IDLE,
		SDU_RUN
	} sdu_state_e;

	// ----------------------------------------
	// One register access
	// ----------------------------------------
	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [`SDU_ADDR_W-1:0] addr;
		logic [31:0]            wdata;
	} sdu_req_s;

endpackage

//--- sim/sdu_cpu_model.sv
// Bus master model standing in for the processor core
`timescale 1ns/1ps
`include "sdu_defs.svh"

module sdu_cpu_model (
	// Clock
	input  wire logic                   clk,
	// Register port
	output logic      [`SDU_ADDR_W-1:0] bus_addr,
	output logic      [31:0]            bus_wdata,
	output logic                        bus_wr,
	output logic                        bus_rd,
	input  wire logic [31:0]            bus_rdata,
	input  wire logic                   bus_rd_valid
);
	initial begin
		bus_addr  = '0;
		bus_wdata = '0;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
	end

	// --------------------------------
	// Access tasks, called just after a rising edge
	// --------------------------------
	// Whole-word write; strobe stays up until the next call
	task automatic wr(input logic [`SDU_ADDR_W-1:0] a, input logic [31:0] d);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		bus_rd    <= 1'b0;
		@(posedge clk);
	endtask

	// Idle cycles; stale write data is scrambled
	task automatic idle(input int n);
		bus_wr    <= 1'b0;
		bus_rd    <= 1'b0;
		bus_wdata <= ~bus_wdata;
		repeat (n) @(posedge clk);
	endtask

	// Whole-word read; lat counts edges from strobe to data
	task automatic rd(input logic [`SDU_ADDR_W-1:0] a, output logic [31:0] d, output int lat);
		bus_addr <= a;
		bus_wr   <= 1'b0;
		bus_rd   <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		lat = 0;
		d   = 'x;
		while (lat < 60) begin
			@(posedge clk);
			lat++;
			if (bus_rd_valid === 1'b1) begin
				d = bus_rdata;
				break;
			end
		end
	endtask
endmodule

//--- sim/test_signed_divide_unit.sv
// Self-checking bench for the signed divide unit
`timescale 1ns/1ps
`include "sdu_defs.svh"

module test_signed_divide_unit;
	logic                   clk          = 1'b0;
	logic                   reset        = 1'b1;
	logic [`SDU_ADDR_W-1:0] bus_addr;
	logic [31:0]            bus_wdata;
	logic                   bus_wr;
	logic                   bus_rd;
	logic [31:0]            bus_rdata;
	logic                   bus_rd_valid;
	logic                   irq;
	logic [`SDU_VEC_W-1:0]  irq_vector;
	logic                   busy;
	logic                   stall;
	int                     busy_cycles  = 0;
	int                     stall_cycles = 0;
	logic [31:0]            rdv;
	int                     lat;
	int                     miscompares  = 0;
	int                     total_checks = 0;
	int                     cycles       = 0;

	always #5 clk = ~clk;

	sdu_cpu_model i_cpu (
		.clk          (clk),
		.bus_addr     (bus_addr),
		.bus_wdata    (bus_wdata),
		.bus_wr       (bus_wr),
		.bus_rd       (bus_rd),
		.bus_rdata    (bus_rdata),
		.bus_rd_valid (bus_rd_valid)
	);

	sdu_divide_unit i_dut (
		.clk                  (clk),
		.reset                (reset),
		.bus_addr             (bus_addr),
		.bus_wdata            (bus_wdata),
		.bus_wr               (bus_wr),
		.bus_rd               (bus_rd),
		.bus_rdata            (bus_rdata),
		.bus_rd_valid         (bus_rd_valid),
		.bus_stall            (stall),
		.busy                 (busy),
		.overflow_irq_request (irq),
		.irq_vector           (irq_vector)
	);

	// --------------------------------
	// Checking and closing
	// --------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [`SDU_ADDR_W-1:0] a, input logic [31:0] exp);
		i_cpu.rd(a, rdv, lat);
		chk(rdv, exp);
	endtask

	// Cycles seen busy or stalling, read as differences
	always @(posedge clk) begin
		busy_cycles  <= busy_cycles + int'(busy === 1'b1);
		stall_cycles <= stall_cycles + int'(stall === 1'b1);
	end

	// Hang guard, runs are about 520 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			give_verdict();
		end
	end

	// --------------------------------
	// Division helper
	// --------------------------------
	function automatic logic [63:0] qr64(input logic [63:0] n, input logic [31:0] d);
		longint q;
		longint r;
		q = $signed(n) / longint'($signed(d));
		r = $signed(n) % longint'($signed(d));
		return {r[31:0], q[31:0]};
	endfunction

	// Quotient checked only when chkq is set; on overflow it is compared with sat
	task automatic divide(input logic [7:0] st, input logic [31:0] hi, lo, dv,
			input logic ovf, input logic chkq, input logic [31:0] sat);
		logic [63:0] n;
		logic [63:0] qr;
		int          b0;
		int          s0;
		n  = (st == `SDU_OFF_LOW) ? {hi, lo} : {{32{lo[31]}}, lo};
		qr = ovf ? {32'h0, sat} : qr64(n, dv);
		i_cpu.wr(`SDU_OFF_DIVISOR, dv);
		i_cpu.idle(1);
		if (st == `SDU_OFF_LOW) begin
			i_cpu.wr(`SDU_OFF_HIGH, hi);
			i_cpu.idle(1);
		end
		b0 = busy_cycles;
		s0 = stall_cycles;
		i_cpu.wr(st, lo);
		i_cpu.rd(st, rdv, lat);
		chk(32'(lat), ovf ? 32'd6 : 32'd39);
		chk(32'(busy_cycles - b0), ovf ? 32'd5 : 32'd38);
		chk(32'(stall_cycles - s0), ovf ? 32'd4 : 32'd37);
		if (chkq) begin
			chk(rdv, qr[31:0]);
			rchk(`SDU_OFF_LOW, qr[31:0]);
		end
		if (!ovf)
			rchk(`SDU_OFF_HIGH, qr[63:32]);
		rchk(`SDU_OFF_DIVISOR, dv);
	endtask

	// --------------------------------
	// Test sequence
	// --------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		i_cpu.idle(1);
		rchk(`SDU_OFF_CTRL, 32'h0);
		rchk(`SDU_OFF_VECTOR, 32'h0);
		rchk(8'h18, 32'h0);
		chk({25'h0, irq_vector}, 32'h0);
		$display("test reset done");

		i_cpu.wr(`SDU_OFF_CTRL, 32'hfffffffc);
		i_cpu.rd(`SDU_OFF_CTRL, rdv, lat);
		chk(32'(lat), 32'd2);
		chk(rdv, 32'h0);
		i_cpu.wr(`SDU_OFF_VECTOR, 32'hffffffff);
		i_cpu.rd(`SDU_OFF_VECTOR, rdv, lat);
		chk(rdv, 32'h7f);
		chk({25'h0, irq_vector}, 32'h7f);
		$display("test registers done");

		divide(`SDU_OFF_LOW, 32'h0, 32'd100, 32'd7, 1'b0, 1'b1, 32'h0);
		divide(`SDU_OFF_LOW, 32'hffffffff, 32'hfffffff0, 32'd3, 1'b0, 1'b1, 32'h0);
		divide(`SDU_OFF_LOW, 32'h1, 32'h0, 32'h7fffffff, 1'b0, 1'b1, 32'h0);
		divide(`SDU_OFF_LOW, 32'hffffffff, 32'h80000000, 32'h1, 1'b0, 1'b1, 32'h0);
		divide(`SDU_OFF_SHORT, 32'h0, 32'h80000005, 32'hfffffffe, 1'b0, 1'b1, 32'h0);
		divide(`SDU_OFF_SHORT, 32'h0, 32'h7fffffff, 32'hffffffff, 1'b0, 1'b1, 32'h0);
		i_cpu.wr(`SDU_OFF_SHORT, 32'd21);
		i_cpu.idle(39);
		i_cpu.rd(`SDU_OFF_SHORT, rdv, lat);
		chk(32'(lat), 32'd1);
		chk(rdv, 32'hffffffeb);
		rchk(`SDU_OFF_CTRL, 32'h0);
		$display("test division done");

		divide(`SDU_OFF_SHORT, 32'h0, 32'h80000000, 32'hffffffff, 1'b1, 1'b1, `SDU_Q_MAX);
		divide(`SDU_OFF_LOW, 32'h1, 32'h0, 32'hffffffff, 1'b1, 1'b1, `SDU_Q_MIN);
		divide(`SDU_OFF_SHORT, 32'h0, 32'd5, 32'h0, 1'b1, 1'b1, `SDU_Q_MAX);
		divide(`SDU_OFF_LOW, 32'hffffffff, 32'h00000001, 32'hfffffffe, 1'b1, 1'b1, `SDU_Q_MAX);
		rchk(`SDU_OFF_CTRL, 32'h1);
		chk({31'h0, irq}, 32'h0);
		divide(`SDU_OFF_SHORT, 32'h0, 32'd9, 32'd2, 1'b0, 1'b1, 32'h0);
		rchk(`SDU_OFF_CTRL, 32'h1);
		$display("test overflow masked done");

		i_cpu.wr(`SDU_OFF_CTRL, 32'h2);
		i_cpu.idle(1);
		rchk(`SDU_OFF_CTRL, 32'h2);
		chk({31'h0, irq}, 32'h0);
		divide(`SDU_OFF_LOW, 32'h0, 32'd5, 32'h0, 1'b1, 1'b1, 32'h2f);
		rchk(`SDU_OFF_HIGH, 32'h0);
		rchk(`SDU_OFF_CTRL, 32'h3);
		chk({31'h0, irq}, 32'h1);
		i_cpu.wr(`SDU_OFF_CTRL, 32'h1);
		i_cpu.idle(2);
		chk({31'h0, irq}, 32'h0);
		$display("test overflow enabled done");
		give_verdict();
	end
endmodule
